/* bss_defs.svh */
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BSS_ADDR_CTRL 8'h18
`define BSS_ADDR_STAT 8'h19
`define BSS_ADDR_CLR 8'h1A
`define BSS_ADDR_IEN 8'h1B
`define BSS_ADDR_MODE 8'h1C

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define BSS_CTRL_SEL_LO 0
`define BSS_CTRL_SEL_HI 1
`define BSS_CTRL_FORCE_OPEN 2
`define BSS_CTRL_DET_DIS 3
`define BSS_CTRL_RST 4'h0

// ----------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------
`define BSS_EV_ALARM 0
`define BSS_EV_TIMER 1
`define BSS_EV_UPDATE 2
`define BSS_EV_TO_BACKUP 3
`define BSS_EV_TO_NORMAL 4
`define BSS_EV_W 5

// ----------------------------------------------------------------
// Timing in nanoseconds
// ----------------------------------------------------------------
`define BSS_CLK_NS 50
`define BSS_DELAY_NS 62500000
`define BSS_WIN0_NS 2000000
`define BSS_WIN1_NS 16000000
`define BSS_WIN2_NS 128000000
`define BSS_WIN3_NS 256000000

`endif

/* bss_pkg.sv */
package bss_pkg;

	typedef enum logic [1:0] {
		BSS_IDLE,
		BSS_DELAY,
		BSS_WINDOW
	} bss_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} bss_req_s;

	typedef struct packed {
		logic alarm;
		logic timer;
		logic update;
	} bss_evt_s;

endpackage : bss_pkg

/* bss_switchover.sv */
// Operation
// - In backup mode the host interface is disabled and the clock output is held low.
// - In backup mode the interrupt pin is released while event flags still set as normal.
// - Compensation runs whenever a supply is above its minimum and battery-low detection always runs.
// - A supply drop is judged only while the switch is open and the comparator enabled.
// - A window that finds the supply at or below threshold keeps the switch open and selects backup.
// - A window that finds the supply above threshold closes the switch and selects normal.
// - In normal mode the switch is closed between the once-per-second windows.
// - Detection of a removed supply may take up to one second.
// - The comparator stays enabled for the whole selected window each second.
// - A clear detector-disable bit enables switchover; when set, the force-open bit fixes the switch.
// - Window select codes 0..3 give 2, 16, 128 and 256 ms and the level is taken at window end.
// - The comparator enable rises 62.5 ms after each seconds increment.
//
// Design decision made here: the plain strobed port.
`include "bss_defs.svh"

module bss_switchover #(
	parameter int unsigned DELAY_CYC = `BSS_DELAY_NS / `BSS_CLK_NS,
	parameter int unsigned WIN0_CYC = `BSS_WIN0_NS / `BSS_CLK_NS,
	parameter int unsigned WIN1_CYC = `BSS_WIN1_NS / `BSS_CLK_NS,
	parameter int unsigned WIN2_CYC = `BSS_WIN2_NS / `BSS_CLK_NS,
	parameter int unsigned WIN3_CYC = `BSS_WIN3_NS / `BSS_CLK_NS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire bss_pkg::bss_req_s bus_req,
	output logic [7:0] bus_rdata,
	input wire logic sec_tick,
	input wire bss_pkg::bss_evt_s evt,
	input wire logic supply_above_thr,
	input wire logic compensation_min_supply_ok,
	input wire logic freq_clock_in,
	output logic freq_clock_out,
	output logic host_if_en,
	output logic int_pin_out,
	output logic int_pin_oe,
	output logic irq,
	output logic switch_open,
	output logic comparator_enable_strobe,
	output logic backup_mode,
	output logic comp_run,
	output logic batt_low_det_en
);
	import bss_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic above_meta_r;
	logic above_s_r;
	logic tmin_meta_r;
	logic tmin_s_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			above_meta_r <= 1'b1;
			above_s_r <= 1'b1;
			tmin_meta_r <= 1'b0;
			tmin_s_r <= 1'b0;
		end else begin
			above_meta_r <= supply_above_thr;
			above_s_r <= above_meta_r;
			tmin_meta_r <= compensation_min_supply_ok;
			tmin_s_r <= tmin_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	logic [3:0] ctrl_r;
	logic [`BSS_EV_W-1:0] stat_r;
	logic [`BSS_EV_W-1:0] ien_r;
	logic [7:0] rdata_r;
	logic backup_r;
	bss_state_e state_r;

	// The bus pins are unpowered in backup mode, so every access is dropped.
	wire bus_live = !backup_r;
	wire wr = bus_req.we && bus_live;
	wire rd = bus_req.re && bus_live;
	wire wr_ctrl = wr && (bus_req.addr == `BSS_ADDR_CTRL);
	wire wr_clr = wr && (bus_req.addr == `BSS_ADDR_CLR);
	wire wr_ien = wr && (bus_req.addr == `BSS_ADDR_IEN);
	wire det_dis = ctrl_r[`BSS_CTRL_DET_DIS];
	wire force_open = ctrl_r[`BSS_CTRL_FORCE_OPEN];
	wire [1:0] win_sel = {ctrl_r[`BSS_CTRL_SEL_HI], ctrl_r[`BSS_CTRL_SEL_LO]};
	wire st_window = (state_r == BSS_WINDOW);
	wire [7:0] mode_word = {5'h00, st_window, switch_open, backup_r};

	logic [7:0] rd_mux;
	always_comb begin
		case (bus_req.addr)
			`BSS_ADDR_CTRL: rd_mux = {4'h0, ctrl_r};
			`BSS_ADDR_STAT: rd_mux = {3'h0, stat_r};
			`BSS_ADDR_IEN: rd_mux = {3'h0, ien_r};
			`BSS_ADDR_MODE: rd_mux = mode_word;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `BSS_CTRL_RST;
			ien_r <= 5'h00;
			rdata_r <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= bus_req.wdata[3:0];
			end
			if (wr_ien) begin
				ien_r <= bus_req.wdata[`BSS_EV_W-1:0];
			end
			rdata_r <= rd ? rd_mux : 8'h00;
		end
	end

	assign bus_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Sampling sequencer
	// ----------------------------------------------------------------
	// Window length is fixed when the window opens, so a select write during it cannot cut it short.
	logic [31:0] win_len;
	always_comb begin
		case (win_sel)
			2'h0: win_len = 32'(WIN0_CYC);
			2'h1: win_len = 32'(WIN1_CYC);
			2'h2: win_len = 32'(WIN2_CYC);
			default: win_len = 32'(WIN3_CYC);
		endcase
	end

	logic [31:0] cnt_r;
	logic [31:0] cur_len_r;
	wire cnt_done = (cnt_r == 32'h0000_0000);
	wire win_end = st_window && cnt_done;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= BSS_IDLE;
			cnt_r <= 32'h0000_0000;
			cur_len_r <= 32'h0000_0000;
			backup_r <= 1'b0;
		end else if (det_dis) begin
			state_r <= BSS_IDLE;
			cnt_r <= 32'h0000_0000;
			backup_r <= 1'b0;
		end else begin
			case (state_r)
				BSS_IDLE: begin
					if (sec_tick) begin
						state_r <= BSS_DELAY;
						cnt_r <= 32'(DELAY_CYC - 1);
					end
				end
				BSS_DELAY: begin
					if (cnt_done) begin
						state_r <= BSS_WINDOW;
						cnt_r <= win_len - 32'h0000_0001;
						cur_len_r <= win_len;
					end else begin
						cnt_r <= cnt_r - 32'h0000_0001;
					end
				end
				BSS_WINDOW: begin
					if (cnt_done) begin
						state_r <= BSS_IDLE;
						backup_r <= !above_s_r;
					end else begin
						cnt_r <= cnt_r - 32'h0000_0001;
					end
				end
				default: begin
					state_r <= BSS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Switch and pin control
	// ----------------------------------------------------------------
	assign comparator_enable_strobe = st_window && !det_dis;
	// Closed between windows in normal mode; open in backup or while sampling.
	assign switch_open = det_dis ? force_open : (st_window || backup_r);
	assign backup_mode = backup_r;
	assign host_if_en = !backup_r;
	assign freq_clock_out = freq_clock_in && !backup_r;
	assign comp_run = tmin_s_r;
	assign batt_low_det_en = 1'b1;

	// ----------------------------------------------------------------
	// Event flags and interrupt
	// ----------------------------------------------------------------
	wire to_backup = win_end && !det_dis && !backup_r && !above_s_r;
	wire to_normal = win_end && !det_dis && backup_r && above_s_r;
	wire [`BSS_EV_W-1:0] ev_set = {to_normal, to_backup, evt.update, evt.timer, evt.alarm};
	wire [`BSS_EV_W-1:0] ev_clr = wr_clr ? bus_req.wdata[`BSS_EV_W-1:0] : 5'h00;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stat_r <= 5'h00;
		end else begin
			// A set in the clearing cycle wins; flags keep running in backup mode.
			stat_r <= (stat_r & ~ev_clr) | ev_set;
		end
	end

	assign irq = |(stat_r & ien_r);
	assign int_pin_out = 1'b0;
	assign int_pin_oe = irq && !backup_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [31:0] on_cnt_r;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			on_cnt_r <= 32'h0000_0000;
		end else begin
			on_cnt_r <= comparator_enable_strobe ? on_cnt_r + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	sequence s_window_closing;
		st_window && cnt_done && !det_dis;
	endsequence

	sequence s_backup_taken;
		backup_r && switch_open && !comparator_enable_strobe;
	endsequence

	a_host_if_off: assert property (@(posedge mclk) disable iff (rst)
		backup_r |-> (!host_if_en && !freq_clock_out && !bus_rdata[0] && !$past(rd)))
		else $error("host interface or clock output active in backup mode");

	a_int_pin_hiz: assert property (@(posedge mclk) disable iff (rst)
		backup_r |-> !int_pin_oe)
		else $error("interrupt pin driven in backup mode");

	a_flag_in_backup: assert property (@(posedge mclk) disable iff (rst)
		(backup_r && evt.alarm) |=> stat_r[`BSS_EV_ALARM])
		else $error("alarm flag not set in backup mode");

	a_aux_running: assert property (@(posedge mclk) disable iff (rst)
		batt_low_det_en && (comp_run == $past(tmin_meta_r)))
		else $error("battery detect or compensation enable wrong");

	a_eval_open_only: assert property (@(posedge mclk) disable iff (rst)
		($changed(backup_r) && !$past(det_dis)) |-> $past(st_window && switch_open))
		else $error("mode changed outside an open sampling window");

	a_drop_to_backup: assert property (@(posedge mclk) disable iff (rst)
		(s_window_closing and !above_s_r) |=> s_backup_taken)
		else $error("low supply did not select backup");

	a_rise_to_normal: assert property (@(posedge mclk) disable iff (rst)
		(s_window_closing and above_s_r) |=> (!backup_r && !switch_open))
		else $error("high supply did not close the switch");

	a_closed_between: assert property (@(posedge mclk) disable iff (rst)
		(!det_dis && !backup_r && !st_window) |-> !switch_open)
		else $error("switch open between windows in normal mode");

	a_window_length: assert property (@(posedge mclk) disable iff (rst)
		$fell(comparator_enable_strobe) && !det_dis |-> ($past(on_cnt_r) + 32'h1 == cur_len_r))
		else $error("comparator window length wrong");

	a_forced_switch: assert property (@(posedge mclk) disable iff (rst)
		det_dis |-> (switch_open == force_open && !comparator_enable_strobe && !backup_r))
		else $error("disabled detector does not follow force-open");

	a_window_start: assert property (@(posedge mclk) disable iff (rst)
		$rose(comparator_enable_strobe) |-> $past(state_r == BSS_DELAY && cnt_done))
		else $error("window opened without the start delay");

	a_clock_low: assert property (@(posedge mclk) disable iff (rst)
		backup_r |-> !freq_clock_out)
		else $error("clock output not low in backup mode");

	a_ctrl_frozen: assert property (@(posedge mclk) disable iff (rst)
		(backup_r && bus_req.we) |=> $stable(ctrl_r))
		else $error("control register written in backup mode");

	a_read_zero: assert property (@(posedge mclk) disable iff (rst)
		(backup_r && $past(backup_r)) |-> (bus_rdata == 8'h00))
		else $error("read data returned in backup mode");

	a_timer_in_backup: assert property (@(posedge mclk) disable iff (rst)
		(backup_r && evt.timer) |=> stat_r[`BSS_EV_TIMER])
		else $error("timer flag not set in backup mode");

	a_update_in_backup: assert property (@(posedge mclk) disable iff (rst)
		(backup_r && evt.update) |=> stat_r[`BSS_EV_UPDATE])
		else $error("update flag not set in backup mode");

	a_set_beats_clear: assert property (@(posedge mclk) disable iff (rst)
		(wr_clr && evt.alarm) |=> stat_r[`BSS_EV_ALARM])
		else $error("clear beat a same-cycle alarm event");

	a_pin_follows: assert property (@(posedge mclk) disable iff (rst)
		(!backup_r && irq) |-> int_pin_oe)
		else $error("interrupt pin not driven in normal mode");

	a_strobe_open: assert property (@(posedge mclk) disable iff (rst)
		comparator_enable_strobe |-> switch_open)
		else $error("comparator enabled with the switch closed");

	a_backup_open: assert property (@(posedge mclk) disable iff (rst)
		(backup_r && !det_dis) |-> switch_open)
		else $error("switch closed in backup mode");

	a_strobe_window: assert property (@(posedge mclk) disable iff (rst)
		!st_window |-> !comparator_enable_strobe)
		else $error("comparator enabled outside a window");

	a_tick_starts: assert property (@(posedge mclk) disable iff (rst)
		(state_r == BSS_IDLE && sec_tick && !det_dis) |=> (state_r == BSS_DELAY))
		else $error("seconds tick did not start the delay");

	a_disable_idles: assert property (@(posedge mclk) disable iff (rst)
		det_dis |=> (state_r == BSS_IDLE))
		else $error("sequencer runs while the detector is disabled");

	a_window_ends: assert property (@(posedge mclk) disable iff (rst)
		win_end |=> (state_r == BSS_IDLE))
		else $error("window did not end after its last cycle");

	a_len_latched: assert property (@(posedge mclk) disable iff (rst)
		st_window |-> (cnt_r < cur_len_r))
		else $error("window counter beyond latched length");

endmodule : bss_switchover

/* bss_supply_model.sv */
module bss_supply_model (
	input wire logic main_on,
	output logic supply_above_thr,
	output logic compensation_min_supply_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	// The battery is taken as always healthy, so compensation never loses its supply.
	assign supply_above_thr = main_on;
	assign compensation_min_supply_ok = 1'b1;
endmodule : bss_supply_model

/* backup_supply_switchover_ctrl_tb.sv */
`include "bss_defs.svh"

module backup_supply_switchover_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bss_pkg::*;
	typedef struct packed {logic [1:0] sel; logic above; logic [3:0] win;} bss_row_s;
	localparam int DLY = 4;
	// Every select code appears at least once, and the mode flips both ways twice.
	localparam bss_row_s ROWS [7] = '{'{2'h0, 1'b1, 4'h2}, '{2'h1, 1'b1, 4'h3},
		'{2'h2, 1'b1, 4'h5}, '{2'h3, 1'b0, 4'h6}, '{2'h3, 1'b1, 4'h6},
		'{2'h0, 1'b0, 4'h2}, '{2'h0, 1'b1, 4'h2}};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sec_tick = 1'b0;
	logic main_on = 1'b1;
	logic fck = 1'b0;
	logic bk_now = 1'b0;
	bss_req_s req = '0;
	bss_evt_s evt = '0;
	logic [7:0] rdata;
	logic fco, hie, ipo, ioe, irq, swo, stb, bk, crun, bld, above, cok;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int d, w;

	always #25 mclk = ~mclk;
	always @(posedge mclk) fck <= ~fck;
	always @(posedge mclk) if (sec_tick) sec_tick <= 1'b0;
	always @(posedge mclk) if (evt != '0) evt <= '0;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	bss_supply_model sup (.main_on(main_on), .supply_above_thr(above),
		.compensation_min_supply_ok(cok));
	bss_switchover #(.DELAY_CYC(DLY), .WIN0_CYC(2), .WIN1_CYC(3), .WIN2_CYC(5),
		.WIN3_CYC(6)) dut (.mclk(mclk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
		.sec_tick(sec_tick), .evt(evt), .supply_above_thr(above),
		.compensation_min_supply_ok(cok), .freq_clock_in(fck), .freq_clock_out(fco),
		.host_if_en(hie), .int_pin_out(ipo), .int_pin_oe(ioe), .irq(irq),
		.switch_open(swo), .comparator_enable_strobe(stb), .backup_mode(bk),
		.comp_run(crun), .batt_low_det_en(bld));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			failures++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] dt);
		@(posedge mclk);
		req <= '{addr: a, wdata: dt, we: 1'b1, re: 1'b0};
		@(posedge mclk);
		req <= '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string msg);
		@(posedge mclk);
		req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge mclk);
		req <= '0;
		#1;
		check(rdata === e, msg);
	endtask : rd

	task automatic tally_and_finish();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check(swo === 1'b0 && bk === 1'b0 && hie === 1'b1 && irq === 1'b0, "reset");
		check(bld === 1'b1 && ipo === 1'b0, "batt detect");
		rd(`BSS_ADDR_CTRL, 8'h00, "ctrl reset");
		rd(8'h20, 8'h00, "unmapped read");
		wr(`BSS_ADDR_IEN, 8'h08);
		rd(`BSS_ADDR_IEN, 8'h08, "ien readback");
		rd(`BSS_ADDR_CLR, 8'h00, "clear reads 0");
		foreach (ROWS[i]) begin
			@(posedge mclk);
			main_on <= ROWS[i].above;
			if (bk_now) evt <= '{alarm: 1'b1, timer: 1'b0, update: 1'b0};
			wr(`BSS_ADDR_CTRL, {6'h00, ROWS[i].sel});
			rd(`BSS_ADDR_CTRL, bk_now ? 8'h00 : {6'h00, ROWS[i].sel}, "ctrl read");
			check(swo === bk_now, "switch between windows");
			@(posedge mclk);
			sec_tick <= 1'b1;
			d = 0;
			do begin
				@(posedge mclk);
				#1;
				d++;
			end while (stb !== 1'b1 && d < 50);
			check(d == DLY + 1, "window start");
			check(swo === 1'b1, "switch open in window");
			w = 0;
			while (stb === 1'b1 && w < 50) begin
				@(posedge mclk);
				#1;
				w++;
			end
			check(w == int'(ROWS[i].win), "window length");
			bk_now = ~ROWS[i].above;
			check(bk === bk_now && swo === bk_now && hie === ~bk_now, "mode");
			check(fco === (fck & ~bk_now), "clock gating");
			check(!bk_now || (irq === 1'b1 && ioe === 1'b0), "pin released");
			check(crun === 1'b1, "compensation");
		end
		rd(`BSS_ADDR_STAT, 8'h19, "status");
		check(ioe === 1'b1, "pin driven");
		wr(`BSS_ADDR_CLR, 8'h1F);
		rd(`BSS_ADDR_STAT, 8'h00, "status cleared");
		check(irq === 1'b0, "irq cleared");
		wr(`BSS_ADDR_IEN, 8'h00);
		@(posedge mclk);
		evt <= '{alarm: 1'b0, timer: 1'b1, update: 1'b0};
		rd(`BSS_ADDR_STAT, 8'h02, "masked status");
		check(irq === 1'b0, "irq masked");
		wr(`BSS_ADDR_CTRL, 8'h0C);
		@(posedge mclk);
		#1;
		check(swo === 1'b1 && bk === 1'b0, "forced open");
		@(posedge mclk);
		sec_tick <= 1'b1;
		d = 0;
		repeat (DLY + 10) begin
			@(posedge mclk);
			#1;
			if (stb === 1'b1) d++;
		end
		check(d == 0, "no sampling when disabled");
		wr(`BSS_ADDR_CTRL, 8'h08);
		@(posedge mclk);
		#1;
		check(swo === 1'b0, "forced closed");
		tally_and_finish();
	end
endmodule : backup_supply_switchover_ctrl_tb
